// [verilog/fosr_host.sv]
// Host controller that polls a parallel NOR flash for status and clears its errors
`default_nettype none
// What the document requires
// RULE_01 - Timeout flag high while toggling means failure; host sends a reset command.
// RULE_02 - After the clearing reset the device may stay busy up to 2 us.
// RULE_03 - Buffer abort flag high; host sends the abort-reset sequence to recover.
// RULE_04 - Buffer programming busy shows complemented data, toggle one, flags clear.
// RULE_05 - Erasing sector reads: data bit 0, both toggles, erase timer set.
// RULE_06 - Outside the erasing sector the second toggle bit stays still.
// RULE_07 - In program suspend the suspended line must not be read.
// RULE_08 - Erase suspended sector reads: data bit 1, only toggle two moves.
// RULE_09 - Programming during erase suspend shows complemented data and toggle one.
// RULE_10 - Host keeps a valid, steady address while reading polling status.
// RULE_11 - After clearing, device returns to overlay, erase suspend or standby.
// RULE_12 - On embedded errors device stays busy, status register valid until cleared.
// RULE_13 - Embedded error polling: timeout flag 1, both toggles, abort flag 0.
// RULE_14 - Embedded error status register: bit 7, bit 5 or 4 set, 3..1 clear.
// RULE_15 - During embedded error only status read, reset or clear are sent.
// RULE_16 - Protection error keeps device busy 20 to 100 us, status bit 7 clear.
// RULE_17 - Protection busy polling: both toggles, timeout flag 0, abort flag 0.
// RULE_18 - During protection busy only the status register read is issued.
// RULE_19 - After protection busy, ready returns with status bits 7 and 1 set.
// RULE_20 - Polling bits 4 and 0, status bits 6 and 0 are masked.
// RULE_21 - Buffer abort sets status bits 7, 4 and 3, timeout flag stays 0.
// RULE_22 - Device ignores commands outside the accepted set while an error pends.
module fosr_host (
  input wire logic pclk, // APB clock, 10 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always high
  output logic pslverr, // APB error on unmapped address
  output fosr_pkg::fosr_flash_t flash, // Flash address, data out, enable and strobes
  input wire logic [15:0] flash_dq_i, // Flash data pins, input side
  input wire logic flash_ready_busy_n // Flash ready/busy pin, low while busy
);
  localparam int A_CLR_MAX = 22;

  fosr_pkg::fosr_state_t st_reg, st_next;
  fosr_pkg::fosr_op_t op_reg, op_next;
  fosr_pkg::fosr_err_t err_reg, err_next;
  fosr_pkg::fosr_flash_t flash_reg, flash_next;
  logic [1:0] step_reg, step_next;
  logic [9:0] cnt_reg, cnt_next, limit_reg, limit_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next, first_reg, first_next;
  logic [7:0] sreg_reg, sreg_next;
  logic done_reg, done_next, refused_reg, refused_next, expired_reg, expired_next;
  logic tog1_reg, tog1_next, tog2_reg, tog2_next, tmo_reg, tmo_next, abt_reg, abt_next;
  logic rb_s1_reg, rb_s2_reg;
  logic [15:0] dq_s1_reg, dq_s2_reg;
  logic stp_write;
  logic [23:0] stp_addr;
  logic [15:0] stp_data;
  logic [1:0] last_step;
  logic [9:0] strobe_len;
  logic wr_acc, start_req, hit, t1, t2;
  fosr_pkg::fosr_op_t req_op;

  assign wr_acc = psel && penable && pwrite;
  assign start_req = wr_acc && (paddr == fosr_pkg::OFF_CTRL);
  assign req_op = fosr_pkg::fosr_op_t'(pwdata[2:0]);
  assign pready = 1'b1;
  assign flash = flash_reg;
  // Bits 4 and 0 of the polling word never enter any decision
  assign t1 = first_reg[fosr_pkg::PB_TOG1] ^ rdata_reg[fosr_pkg::PB_TOG1]; // [RULE_20]
  assign t2 = first_reg[fosr_pkg::PB_TOG2] ^ rdata_reg[fosr_pkg::PB_TOG2];

  // APB read mux and decode
  always_comb
  begin
    hit = 1'b1;
    prdata = 32'h00000000;
    unique case (paddr)
      fosr_pkg::OFF_CTRL: prdata = {29'h00000000, op_reg};
      fosr_pkg::OFF_ADDR: prdata = {8'h00, addr_reg};
      fosr_pkg::OFF_WDATA: prdata = {16'h0000, wdata_reg};
      fosr_pkg::OFF_STAT: prdata = {20'h00000, err_reg, rb_s2_reg, expired_reg, abt_reg,
        tmo_reg, tog2_reg, tog1_reg, refused_reg, done_reg, st_reg != fosr_pkg::S_IDLE};
      fosr_pkg::OFF_RDATA: prdata = {16'h0000, rdata_reg};
      fosr_pkg::OFF_SREG: prdata = {24'h000000, sreg_reg};
      default: hit = 1'b0;
    endcase
    pslverr = psel && penable && !hit;
  end

  // Bus cycles that make up the current operation
  always_comb
  begin
    stp_write = 1'b0;
    stp_addr = addr_reg; // Reads go only to software's address [RULE_07]
    stp_data = wdata_reg;
    last_step = 2'd0;
    unique case (op_reg)
      fosr_pkg::OP_READ, fosr_pkg::OP_WAIT: ;
      fosr_pkg::OP_WRITE: stp_write = 1'b1;
      fosr_pkg::OP_POLL: last_step = 2'd1; // [RULE_10]
      fosr_pkg::OP_SR_READ:
      begin
        last_step = 2'd1;
        if (step_reg == 2'd0)
        begin
          stp_write = 1'b1;
          stp_addr = fosr_pkg::ADDR_UNLOCK1;
          stp_data = fosr_pkg::CMD_SR_READ;
        end
      end
      fosr_pkg::OP_CLEAR:
      begin
        stp_write = 1'b1;
        stp_addr = fosr_pkg::ADDR_UNLOCK1;
        if (err_reg == fosr_pkg::ERR_ABORT)
        begin
          last_step = 2'd2; // [RULE_03]
          if (step_reg == 2'd0)
            stp_data = fosr_pkg::CMD_UNLOCK1;
          else if (step_reg == 2'd1)
          begin
            stp_addr = fosr_pkg::ADDR_UNLOCK2;
            stp_data = fosr_pkg::CMD_UNLOCK2;
          end
          else
            stp_data = fosr_pkg::CMD_RESET;
        end
        else if (err_reg == fosr_pkg::ERR_EMBED)
          stp_data = fosr_pkg::CMD_SR_CLEAR; // [RULE_15]
        else
          stp_data = fosr_pkg::CMD_RESET; // [RULE_01]
      end
    endcase
    strobe_len = stp_write ? fosr_pkg::WE_CYC : fosr_pkg::RD_CYC;
  end

  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    err_next = err_reg;
    step_next = step_reg;
    cnt_next = cnt_reg;
    limit_next = limit_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    first_next = first_reg;
    sreg_next = sreg_reg;
    done_next = done_reg;
    refused_next = refused_reg;
    expired_next = expired_reg;
    tog1_next = tog1_reg;
    tog2_next = tog2_reg;
    tmo_next = tmo_reg;
    abt_next = abt_reg;
    // Address and data only change while idle, so status reads see a steady address
    if (wr_acc && st_reg == fosr_pkg::S_IDLE && paddr == fosr_pkg::OFF_ADDR)
      addr_next = pwdata[23:0]; // [RULE_10]
    if (wr_acc && st_reg == fosr_pkg::S_IDLE && paddr == fosr_pkg::OFF_WDATA)
      wdata_next = pwdata[15:0];
    unique case (st_reg)
      fosr_pkg::S_IDLE:
        if (start_req)
        begin
          if (pwdata[2:0] > 3'd5)
            refused_next = 1'b1;
          else if (err_reg == fosr_pkg::ERR_PROT && req_op != fosr_pkg::OP_SR_READ
                   && req_op != fosr_pkg::OP_WAIT)
            refused_next = 1'b1; // [RULE_18]
          else if (err_reg != fosr_pkg::ERR_NONE && req_op == fosr_pkg::OP_WRITE)
            refused_next = 1'b1; // [RULE_15]
          else
          begin
            refused_next = 1'b0;
            done_next = 1'b0;
            expired_next = 1'b0;
            op_next = req_op;
            step_next = 2'd0;
            cnt_next = 10'd0;
            limit_next = fosr_pkg::PROT_BUSY_CYC; // [RULE_16]
            st_next = (req_op == fosr_pkg::OP_WAIT) ? fosr_pkg::S_WAITRDY : fosr_pkg::S_SETUP;
          end
        end
      fosr_pkg::S_SETUP:
      begin
        cnt_next = 10'd0;
        st_next = fosr_pkg::S_STROBE;
      end
      fosr_pkg::S_STROBE:
        if (cnt_reg == strobe_len - 10'd1)
        begin
          cnt_next = 10'd0;
          st_next = fosr_pkg::S_HOLD;
          if (!stp_write)
          begin
            first_next = rdata_reg;
            rdata_next = dq_s2_reg;
          end
        end
        else
          cnt_next = cnt_reg + 10'd1;
      fosr_pkg::S_HOLD:
        if (cnt_reg == fosr_pkg::HOLD_CYC - 10'd1)
        begin
          cnt_next = 10'd0;
          if (step_reg == last_step)
            st_next = fosr_pkg::S_EVAL;
          else
          begin
            step_next = step_reg + 2'd1;
            st_next = fosr_pkg::S_SETUP;
          end
        end
        else
          cnt_next = cnt_reg + 10'd1;
      fosr_pkg::S_EVAL:
      begin
        st_next = fosr_pkg::S_IDLE;
        done_next = 1'b1;
        unique case (op_reg)
          fosr_pkg::OP_POLL:
          begin
            tog1_next = t1;
            tog2_next = t2;
            tmo_next = rdata_reg[fosr_pkg::PB_TIMEOUT];
            abt_next = rdata_reg[fosr_pkg::PB_ABORT];
            // A timeout only counts while the operation still toggles
            if (rdata_reg[fosr_pkg::PB_TIMEOUT] && t1)
              err_next = fosr_pkg::ERR_TIMEOUT; // [RULE_01]
            else if (rdata_reg[fosr_pkg::PB_ABORT] && t1)
              err_next = fosr_pkg::ERR_ABORT; // [RULE_03]
          end
          fosr_pkg::OP_SR_READ:
          begin
            sreg_next = rdata_reg[7:0] & fosr_pkg::SR_MASK; // [RULE_20]
            if (!rb_s2_reg && !rdata_reg[fosr_pkg::SR_VALID])
              err_next = fosr_pkg::ERR_PROT; // [RULE_16]
            else if (!rb_s2_reg && rdata_reg[fosr_pkg::SR_ABORT])
              err_next = fosr_pkg::ERR_ABORT; // [RULE_03]
            else if (!rb_s2_reg && (rdata_reg[fosr_pkg::SR_ERASE_ERR]
                                   || rdata_reg[fosr_pkg::SR_PROG_ERR]))
              err_next = fosr_pkg::ERR_EMBED; // [RULE_15]
            else if (err_reg == fosr_pkg::ERR_PROT && rb_s2_reg)
              err_next = fosr_pkg::ERR_NONE;
          end
          fosr_pkg::OP_CLEAR:
          begin
            // The device may still report busy briefly after the clear
            done_next = 1'b0;
            err_next = fosr_pkg::ERR_NONE;
            cnt_next = 10'd0;
            limit_next = fosr_pkg::CLR_BUSY_CYC; // [RULE_02]
            st_next = fosr_pkg::S_WAITRDY;
          end
          fosr_pkg::OP_READ, fosr_pkg::OP_WRITE, fosr_pkg::OP_WAIT: ;
        endcase
      end
      fosr_pkg::S_WAITRDY:
        if (rb_s2_reg)
        begin
          done_next = 1'b1;
          if (op_reg == fosr_pkg::OP_WAIT && err_reg == fosr_pkg::ERR_PROT)
            err_next = fosr_pkg::ERR_NONE; // [RULE_19]
          st_next = fosr_pkg::S_IDLE;
        end
        else if (cnt_reg == limit_reg)
        begin
          done_next = 1'b1;
          expired_next = 1'b1;
          st_next = fosr_pkg::S_IDLE;
        end
        else
          cnt_next = cnt_reg + 10'd1;
    endcase
    // Pin drive follows the bus-cycle phase; read strobe never overlaps data drive
    flash_next.addr = stp_addr;
    flash_next.dq_o = stp_data;
    flash_next.dq_oe = stp_write && (st_reg == fosr_pkg::S_SETUP
      || st_reg == fosr_pkg::S_STROBE || st_reg == fosr_pkg::S_HOLD);
    flash_next.ce_n = !(st_reg == fosr_pkg::S_SETUP || st_reg == fosr_pkg::S_STROBE);
    flash_next.oe_n = !(st_reg == fosr_pkg::S_STROBE && !stp_write);
    flash_next.we_n = !(st_reg == fosr_pkg::S_STROBE && stp_write);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= fosr_pkg::S_IDLE;
      op_reg <= fosr_pkg::OP_READ;
      err_reg <= fosr_pkg::ERR_NONE;
      flash_reg <= '{addr: 24'h000000, dq_o: 16'h0000, dq_oe: 1'b0,
                     ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      step_reg <= 2'd0;
      cnt_reg <= 10'h000;
      limit_reg <= 10'h000;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      first_reg <= 16'h0000;
      sreg_reg <= 8'h00;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      expired_reg <= 1'b0;
      tog1_reg <= 1'b0;
      tog2_reg <= 1'b0;
      tmo_reg <= 1'b0;
      abt_reg <= 1'b0;
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      err_reg <= err_next;
      flash_reg <= flash_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      limit_reg <= limit_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      first_reg <= first_next;
      sreg_reg <= sreg_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
      expired_reg <= expired_next;
      tog1_reg <= tog1_next;
      tog2_reg <= tog2_next;
      tmo_reg <= tmo_next;
      abt_reg <= abt_next;
      rb_s1_reg <= flash_ready_busy_n;
      rb_s2_reg <= rb_s1_reg;
      dq_s1_reg <= flash_dq_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // Own count of cycles spent waiting for ready, kept apart from the wait logic it checks
  logic [10:0] wait_len_reg, wait_len_next;
  always_comb
  begin
    wait_len_next = 11'h000;
    if (st_reg == fosr_pkg::S_WAITRDY)
      wait_len_next = wait_len_reg + 11'h001;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_len_reg <= 11'h000;
    else
      wait_len_reg <= wait_len_next;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clear_timeout;
    st_reg == fosr_pkg::S_SETUP && op_reg == fosr_pkg::OP_CLEAR
      && err_reg == fosr_pkg::ERR_TIMEOUT;
  endsequence
  sequence s_abort_last;
    st_reg == fosr_pkg::S_SETUP && op_reg == fosr_pkg::OP_CLEAR
      && err_reg == fosr_pkg::ERR_ABORT && step_reg == 2'd2;
  endsequence

  a_no_bus_fight: assert property (!flash_reg.oe_n |-> !flash_reg.dq_oe)
    else $error("read strobe while data driven");
  a_timeout_seen: assert property ( // [RULE_01]
    (st_reg == fosr_pkg::S_EVAL && op_reg == fosr_pkg::OP_POLL
      && rdata_reg[fosr_pkg::PB_TIMEOUT] && t1) |=> err_reg == fosr_pkg::ERR_TIMEOUT)
    else $error("timeout not recorded");
  a_reset_sent: assert property (s_clear_timeout |=> ##1 // [RULE_01]
    flash_reg.dq_o == fosr_pkg::CMD_RESET && !flash_reg.we_n && flash_reg.dq_oe)
    else $error("reset command not driven");
  a_abort_reset: assert property (s_abort_last |=> ##1 // [RULE_03]
    flash_reg.dq_o == fosr_pkg::CMD_RESET && flash_reg.addr == fosr_pkg::ADDR_UNLOCK1)
    else $error("abort reset sequence wrong");
  a_clear_wait: assert property ( // [RULE_02]
    (st_reg == fosr_pkg::S_WAITRDY && limit_reg == fosr_pkg::CLR_BUSY_CYC)
      |-> ##[0:A_CLR_MAX] st_reg == fosr_pkg::S_IDLE)
    else $error("clear wait too long");
  a_prot_wait: assert property ( // [RULE_16]
    (st_reg == fosr_pkg::S_WAITRDY && op_reg == fosr_pkg::OP_WAIT)
      |-> wait_len_reg <= {1'b0, fosr_pkg::PROT_BUSY_CYC})
    else $error("protection wait too long");
  a_prot_refuse: assert property ( // [RULE_18]
    (st_reg == fosr_pkg::S_IDLE && start_req && err_reg == fosr_pkg::ERR_PROT
      && (req_op == fosr_pkg::OP_CLEAR || req_op == fosr_pkg::OP_POLL))
      |=> refused_reg && st_reg == fosr_pkg::S_IDLE)
    else $error("command sent during protection busy");
  a_error_refuse: assert property ( // [RULE_15]
    (st_reg == fosr_pkg::S_IDLE && start_req && err_reg == fosr_pkg::ERR_EMBED
      && req_op == fosr_pkg::OP_WRITE) |=> refused_reg && flash_reg.we_n)
    else $error("write sent during error status");
  a_poll_addr: assert property ( // [RULE_10]
    (op_reg == fosr_pkg::OP_POLL && st_reg != fosr_pkg::S_IDLE) |-> $stable(addr_reg))
    else $error("poll address moved");
  a_sr_masked: assert property ( // [RULE_20]
    (st_reg == fosr_pkg::S_EVAL && op_reg == fosr_pkg::OP_SR_READ)
      |=> sreg_reg[6] == 1'b0 && sreg_reg[0] == 1'b0)
    else $error("masked status bits kept");
endmodule
`default_nettype wire

// [verilog/fosr_pkg.sv]
// Constants, types and register map of the flash status and error host controller
`default_nettype none
package fosr_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYNC_STAGES = 2;
  localparam int ADDR_W = 24;
  localparam int DQ_W = 16;
  // Bus cycle times on the flash pins
  localparam int T_READ_NS = 120;
  localparam int T_WE_NS = 60;
  localparam int T_HOLD_NS = 30;
  // Busy after a clearing reset, and longest protection busy period
  localparam int T_CLR_BUSY_NS = 2000;
  localparam int T_PROT_BUSY_MAX_NS = 100000;
  // Least times round up; the extra cycles cover the pin synchroniser and the output register
  localparam logic [9:0] RD_CYC =
    10'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1);
  localparam logic [9:0] WE_CYC = 10'((T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] HOLD_CYC = 10'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Longest times round down
  localparam logic [9:0] CLR_BUSY_CYC = 10'(T_CLR_BUSY_NS / CLK_PERIOD_NS);
  localparam logic [9:0] PROT_BUSY_CYC = 10'(T_PROT_BUSY_MAX_NS / CLK_PERIOD_NS);
  // APB register offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ADDR = 12'h004;
  localparam logic [11:0] OFF_WDATA = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00C;
  localparam logic [11:0] OFF_RDATA = 12'h010;
  localparam logic [11:0] OFF_SREG = 12'h014;
  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_TOG1 = 3;
  localparam int ST_TOG2 = 4;
  localparam int ST_TIMEOUT = 5;
  localparam int ST_ABORT = 6;
  localparam int ST_EXPIRED = 7;
  localparam int ST_READY = 8;
  localparam int ST_ERR_LSB = 9;
  // Polling bit positions on the data bus
  localparam int PB_DATA = 7;
  localparam int PB_TOG1 = 6;
  localparam int PB_TIMEOUT = 5;
  localparam int PB_TOG2 = 2;
  localparam int PB_ABORT = 1;
  // Operation status register fields
  localparam int SR_VALID = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_ABORT = 3;
  localparam int SR_PROT = 1;
  localparam logic [7:0] SR_MASK = 8'hBE;
  // Flash commands and unlock addresses
  localparam logic [DQ_W-1:0] CMD_RESET = 16'h00F0;
  localparam logic [DQ_W-1:0] CMD_SR_READ = 16'h0070;
  localparam logic [DQ_W-1:0] CMD_SR_CLEAR = 16'h0071;
  localparam logic [DQ_W-1:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [DQ_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 24'h000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 24'h0002AA;

  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_POLL, OP_SR_READ, OP_CLEAR, OP_WAIT} fosr_op_t;
  typedef enum logic [2:0] {ERR_NONE, ERR_TIMEOUT, ERR_ABORT, ERR_EMBED, ERR_PROT} fosr_err_t;
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_EVAL, S_WAITRDY} fosr_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fosr_flash_t;
endpackage
`default_nettype wire

// [tb/fosr_flash_model.sv]
// Behavioural flash device that answers status polls and clearing commands
`default_nettype none
module fosr_flash_model (
  input wire fosr_pkg::fosr_flash_t flash, // Pins from the host
  input wire logic [2:0] inject, // Error to raise, 0 for none
  output logic [15:0] dq, // Data pins toward the host
  output logic ready_busy_n // Low while busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] err = 3'h0;
  logic [7:0] sr = 8'h00;
  logic [15:0] q = 16'h0000;
  logic tog = 1'b0;
  logic sr_next = 1'b0;
  logic [1:0] ul = 2'h0;
  logic in_sec;
  initial ready_busy_n = 1'b1;
  // Released pins show the inverse, so a stale value can never pass as a read
  assign dq = (!flash.ce_n && !flash.oe_n) ? q : ~q;
  // Sector zero stands for the sector that is erasing or erase-suspended
  assign in_sec = (flash.addr[23:16] == 8'h00);

  task automatic clear_err(input int d);
    err = 3'h0;
    sr = 8'h00;
    ul = 2'h0;
    ready_busy_n <= #(d) 1'b1;
  endtask

  always @(negedge flash.oe_n)
  begin
    tog = ~tog;
    if (sr_next)
      q = {8'h00, sr};
    else
      case (err)
        3'h1: q = {8'h00, 1'b1, tog, 6'b100000};
        3'h2: q = {8'h00, 1'b1, tog, 6'b000010};
        3'h3: q = {8'h00, 1'b0, tog, 3'b101, tog, 2'b00};
        3'h4: q = {8'h00, 1'b0, tog, 3'b001, tog, 2'b00};
        3'h5: q = {8'h00, 1'b0, tog, 6'b000000};
        3'h6: q = {8'h00, 1'b0, tog, 3'b001, tog & in_sec, 2'b00};
        3'h7: q = in_sec ? {8'h00, 1'b1, 1'b0, 3'b000, tog, 2'b00}
                         : flash.addr[15:0] ^ 16'hA5C3;
        default: q = flash.addr[15:0] ^ 16'hA5C3;
      endcase
    sr_next = 1'b0;
  end

  always @(negedge flash.we_n)
  begin
    if (flash.dq_o == fosr_pkg::CMD_SR_READ)
      sr_next = 1'b1;
    else if (err == 3'h1 && flash.dq_o == fosr_pkg::CMD_RESET)
      clear_err(1500);
    else if (err == 3'h3 && flash.dq_o inside {fosr_pkg::CMD_RESET, fosr_pkg::CMD_SR_CLEAR})
      clear_err(0);
    else if (err == 3'h2 && flash.dq_o == fosr_pkg::CMD_UNLOCK1)
      ul = 2'h1;
    else if (err == 3'h2 && ul == 2'h1 && flash.addr == fosr_pkg::ADDR_UNLOCK2)
      ul = 2'h2;
    else if (err == 3'h2 && ul == 2'h2 && flash.dq_o == fosr_pkg::CMD_RESET)
      clear_err(0);
    else
      ul = 2'h0;
  end

  always @(inject)
  begin
    if (inject != 3'h0)
    begin
      err = inject;
      ready_busy_n = (inject == 3'h7);
      case (inject)
        3'h1: sr = 8'h90;
        3'h2: sr = 8'h98;
        3'h3: sr = 8'hA0;
        default: sr = 8'h00;
      endcase
      if (inject inside {3'h4, 3'h5, 3'h6})
      begin
        // Busy time of 30 us, near the short end, well inside the host's longest wait
        #30000;
        sr = (err == 3'h4) ? 8'h92 : 8'h80;
        err = 3'h0;
        ready_busy_n = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the flash status and error host controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fosr_pkg::fosr_flash_t flash;
  logic [15:0] dq;
  logic rbn;
  logic [2:0] inject = 3'h0;
  logic [31:0] rd;
  logic slv_seen;
  int miscompares = 0;
  int tests_run = 0;

  fosr_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash(flash), .flash_dq_i(dq), .flash_ready_busy_n(rbn));
  fosr_flash_model model (.flash(flash), .inject(inject), .dq(dq), .ready_busy_n(rbn));

  initial
  begin
    forever #50 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("Mismatches %0d of %0d checks", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_st(input string name, input logic [31:0] exp, input logic [31:0] mask);
    chk(name, exp, rd & mask);
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    stop_test();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      hang("pready");
    rd = prdata;
    slv_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Leaves the final status word in rd
  task automatic run_op(input logic [2:0] op, input int lim);
    int n;
    apb(1'b1, fosr_pkg::OFF_CTRL, {29'h0, op});
    n = 0;
    do
    begin
      apb(1'b0, fosr_pkg::OFF_STAT, 32'h0);
      n++;
    end
    while (rd[fosr_pkg::ST_BUSY] !== 1'b0 && n < lim);
    if (rd[fosr_pkg::ST_BUSY] !== 1'b0)
      hang("busy");
  endtask

  // Give the pin synchroniser time to see the busy level
  task automatic raise(input logic [2:0] k);
    inject <= k;
    @(posedge pclk);
    inject <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset();
    repeat (4) @(posedge pclk);
    apb(1'b0, fosr_pkg::OFF_STAT, 32'h0);
    chk("stat after reset", 32'h100, rd);
    apb(1'b0, fosr_pkg::OFF_SREG, 32'h0);
    chk("status reg after reset", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, slv_seen});
  endtask

  task automatic t_read();
    apb(1'b1, fosr_pkg::OFF_ADDR, 32'h001234);
    run_op(fosr_pkg::OP_READ, 20);
    apb(1'b0, fosr_pkg::OFF_RDATA, 32'h0);
    chk("array read", 32'h1234 ^ 32'hA5C3, rd);
  endtask

  task automatic t_timeout();
    raise(3'h1);
    run_op(fosr_pkg::OP_POLL, 20);
    chk_st("timeout poll", 32'h222, 32'hF62);
    run_op(fosr_pkg::OP_CLEAR, 40);
    chk_st("timeout cleared", 32'h102, 32'hF83);
  endtask

  task automatic t_abort();
    raise(3'h2);
    run_op(fosr_pkg::OP_POLL, 20);
    chk_st("abort poll", 32'h442, 32'hF62);
    run_op(fosr_pkg::OP_SR_READ, 20);
    apb(1'b0, fosr_pkg::OFF_SREG, 32'h0);
    chk("abort status reg", 32'h98, rd);
    run_op(fosr_pkg::OP_CLEAR, 40);
    chk_st("abort cleared", 32'h102, 32'hF83);
  endtask

  task automatic t_embedded();
    raise(3'h3);
    run_op(fosr_pkg::OP_SR_READ, 20);
    chk_st("embedded kind", 32'h602, 32'hF06);
    apb(1'b0, fosr_pkg::OFF_SREG, 32'h0);
    chk("embedded status reg", 32'hA0, rd);
    run_op(fosr_pkg::OP_WRITE, 20);
    chk_st("write refused", 32'h606, 32'hF06);
    run_op(fosr_pkg::OP_CLEAR, 40);
    chk_st("embedded cleared", 32'h102, 32'hF83);
  endtask

  task automatic t_prot();
    raise(3'h4);
    run_op(fosr_pkg::OP_SR_READ, 20);
    chk_st("protection kind", 32'h802, 32'hF06);
    apb(1'b0, fosr_pkg::OFF_SREG, 32'h0);
    chk("protection busy status reg", 32'h0, rd);
    run_op(fosr_pkg::OP_POLL, 20);
    chk_st("poll refused", 32'h806, 32'hF06);
    run_op(fosr_pkg::OP_WAIT, 400);
    chk_st("protection over", 32'h102, 32'hF83);
    run_op(fosr_pkg::OP_SR_READ, 20);
    apb(1'b0, fosr_pkg::OFF_SREG, 32'h0);
    chk("protection status reg", 32'h92, rd);
  endtask

  task automatic t_busy();
    raise(3'h5);
    run_op(fosr_pkg::OP_POLL, 20);
    chk_st("buffer busy poll", 32'h00A, 32'hF7A);
    apb(1'b0, fosr_pkg::OFF_RDATA, 32'h0);
    chk("buffer busy data bit", 32'h0, rd & 32'h80);
    run_op(fosr_pkg::OP_WAIT, 400);
    raise(3'h6);
    run_op(fosr_pkg::OP_POLL, 20);
    chk_st("erasing sector poll", 32'h01A, 32'hF7A);
    apb(1'b0, fosr_pkg::OFF_RDATA, 32'h0);
    chk("erasing sector bits", 32'h08, rd & 32'h88);
    apb(1'b1, fosr_pkg::OFF_ADDR, 32'h011234);
    run_op(fosr_pkg::OP_POLL, 20);
    chk_st("outside erasing poll", 32'h00A, 32'hF7A);
    run_op(fosr_pkg::OP_WAIT, 400);
    chk_st("erase over", 32'h102, 32'hF83);
  endtask

  task automatic t_suspend();
    raise(3'h7);
    apb(1'b1, fosr_pkg::OFF_ADDR, 32'h001234);
    run_op(fosr_pkg::OP_POLL, 20);
    chk_st("suspended sector poll", 32'h112, 32'hF7A);
    apb(1'b0, fosr_pkg::OFF_RDATA, 32'h0);
    chk("suspended sector data bit", 32'h80, rd & 32'h80);
    apb(1'b1, fosr_pkg::OFF_ADDR, 32'h020055);
    run_op(fosr_pkg::OP_READ, 20);
    apb(1'b0, fosr_pkg::OFF_RDATA, 32'h0);
    chk("other sector read", 32'h0055 ^ 32'hA5C3, rd);
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_read();
    t_timeout();
    t_abort();
    t_embedded();
    t_prot();
    t_busy();
    t_suspend();
    stop_test();
  end
endmodule
`default_nettype wire
